// ---- hdl/rsb_speed_selector.sv ----
// Ring speed selector: button procedure, speed code store, node address and APB registers.
// Assumes an external nonvolatile store that answers each write with ok or fail,
// and a system that resets the drive when drive_rst_req pulses.
`timescale 1ns/100ps
`default_nettype none
module rsb_speed_selector
   import rsb_pkg::*;
#(
   parameter int unsigned DEB_N   = DEB_CYC,
   parameter int unsigned SHORT_N = SHORT_CYC,
   parameter int unsigned LONG_N  = LONG_CYC,
   parameter int unsigned IDLE_N  = IDLE_CYC
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              sys_rst,
   // APB slave
   input  wire logic [11:0]       paddr,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Operator button and display
   input  wire logic              boot_btn_n,
   input  wire logic [7:0]        status_sym,
   output var  rsb_disp_s         disp,
   // Node address switch
   input  wire logic [NODE_W-1:0] node_sw,
   // Nonvolatile store
   input  wire logic [CODE_W-1:0] nv_boot_code,
   output var  rsb_nv_req_s       nv_req,
   input  wire rsb_nv_rsp_s       nv_rsp,
   // Drive side
   output logic [CODE_W-1:0]      link_speed_code_param,
   output logic [CODE_W-1:0]      ring_rate_mbd,
   output logic [ID_W-1:0]        host_drive_bus_id,
   output logic                   node_ignored,
   output logic                   ring_en,
   output logic                   fieldbus_en,
   output logic                   drive_rst_req
);

   // Whole block state in one record
   typedef struct packed {
      rsb_st_e           st;
      logic [1:0]        init_cnt;
      logic [NODE_W-1:0] sw_s1;
      logic [NODE_W-1:0] sw_s2;
      logic [NODE_W-1:0] node;
      logic [EXT_W-1:0]  ext;
      logic              fb_sel;
      logic [CODE_W-1:0] stored;
      logic [CODE_W-1:0] cand;
      logic [31:0]       idle_cnt;
      logic              err_nv;
      logic              err_code;
      logic              rst_pls;
      logic [31:0]       rdata;
      rsb_disp_s         disp;
   } rsb_top_s;

   rsb_top_s top_reg;
   rsb_top_s top_next;

   logic btn_held;
   logic btn_short;
   logic btn_long;

   // Button timing
   rsb_press_timer #(
      .DEB_N   (DEB_N),
      .SHORT_N (SHORT_N),
      .LONG_N  (LONG_N)
   ) u_press (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .btn_n     (boot_btn_n),
      .pressed   (btn_held),
      .short_pls (btn_short),
      .long_pls  (btn_long)
   );

   // APB decode
   logic        setup_ph;
   logic        wr_acc;
   logic        addr_hit;
   logic [31:0] rd_mux;
   logic [ID_W-1:0] eff_id;
   logic        spd_wr_ok;

   assign setup_ph = psel && !penable;
   assign wr_acc   = psel && penable && pwrite;
   assign addr_hit = (paddr == OFS_CTRL) || (paddr == OFS_STAT) ||
                     (paddr == OFS_SPEED) || (paddr == OFS_NODE);
   assign spd_wr_ok = code_valid(pwdata[CODE_W-1:0]) && (pwdata[31:CODE_W] == '0);

   // Identifier extended beyond the switch range
   assign eff_id = ID_W'(top_reg.node) + ID_W'(ID_STEP * ID_W'(top_reg.ext));

   // Read data, captured in the setup phase so it is stable in access
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (paddr)
         OFS_CTRL: begin
            rd_mux[EXT_W-1:0]  = top_reg.ext;
            rd_mux[CTRL_FB_BIT] = top_reg.fb_sel;
         end
         OFS_STAT: begin
            rd_mux[2:0]                                 = top_reg.st;
            rd_mux[STAT_ENV_BIT]                        = top_reg.err_nv;
            rd_mux[STAT_ECOD_BIT]                       = top_reg.err_code;
            rd_mux[STAT_CAND_LSB +: CODE_W]             = top_reg.cand;
         end
         OFS_SPEED: begin
            rd_mux[CODE_W-1:0]              = top_reg.stored;
            rd_mux[SPD_MBD_LSB +: CODE_W]   = code_mbd(top_reg.stored);
         end
         OFS_NODE: begin
            rd_mux[NODE_W-1:0]             = top_reg.node;
            rd_mux[NODE_ID_LSB +: ID_W]    = eff_id;
            rd_mux[NODE_IGN_BIT]           = (top_reg.node == '0);
            rd_mux[NODE_IDN_LSB +: 4]      = FAST_IDN;
            rd_mux[NODE_WRD_LSB +: CODE_W] = FAST_WORDS;
         end
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // Next-state logic for the selector, store and registers
   always_comb begin
      top_next         = top_reg;
      top_next.sw_s1   = node_sw;
      top_next.sw_s2   = top_reg.sw_s1;
      top_next.rst_pls = 1'b0;
      if (setup_ph) begin
         top_next.rdata = rd_mux;
      end

      // Register writes; status flags clear by writing one
      if (wr_acc && top_reg.st != ST_BOOT) begin
         case (paddr)
            OFS_CTRL: begin
               top_next.ext    = pwdata[EXT_W-1:0];
               top_next.fb_sel = pwdata[CTRL_FB_BIT];
            end
            OFS_STAT: begin
               if (pwdata[STAT_ENV_BIT]) begin
                  top_next.err_nv = 1'b0;
               end
               if (pwdata[STAT_ECOD_BIT]) begin
                  top_next.err_code = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end

      case (top_reg.st)
         // Let the switch synchroniser settle, then take strap and stored code
         ST_BOOT: begin
            top_next.init_cnt = top_reg.init_cnt + 2'h1;
            if (top_reg.init_cnt == INIT_DONE) begin
               top_next.node   = top_reg.sw_s2;
               top_next.stored = nv_boot_code;
               top_next.cand   = code_norm(nv_boot_code);
               top_next.st     = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (btn_long) begin
               top_next.cand     = code_norm(top_reg.stored);
               top_next.idle_cnt = 32'h0000_0000;
               top_next.st       = ST_SELECT;
            end
         end
         ST_SELECT: begin
            // Leaving here touches only the candidate, never the stored code
            if (btn_held) begin
               top_next.idle_cnt = 32'h0000_0000;
            end else if (top_reg.idle_cnt >= IDLE_N - 1) begin
               top_next.st = ST_IDLE;
            end else begin
               top_next.idle_cnt = top_reg.idle_cnt + 32'h0000_0001;
            end
            if (btn_short) begin
               top_next.cand = code_next(top_reg.cand);
            end
            if (btn_long) begin
               if (code_valid(top_reg.cand)) begin
                  top_next.st = ST_SAVE;
               end else begin
                  top_next.err_code = 1'b1;
               end
            end
         end
         // Stored value follows only a confirmed save
         ST_SAVE: begin
            if (nv_rsp.fail) begin
               top_next.err_nv = 1'b1;
               top_next.st     = ST_ERROR;
            end else if (nv_rsp.ok) begin
               top_next.stored  = top_reg.cand;
               top_next.rst_pls = 1'b1;
               top_next.st      = ST_RESTART;
            end
         end
         ST_ERROR: begin
            if (!btn_held) begin
               top_next.idle_cnt = 32'h0000_0000;
               top_next.st       = ST_SELECT;
            end
         end
         ST_RESTART: begin
            top_next.st = ST_IDLE;
         end
         default: top_next.st = ST_IDLE;
      endcase

      // Software commit; taken only when the operator is not mid-save
      if (wr_acc && paddr == OFS_SPEED &&
          (top_reg.st == ST_IDLE || top_reg.st == ST_SELECT)) begin
         if (spd_wr_ok) begin
            top_next.cand = pwdata[CODE_W-1:0];
            top_next.st   = ST_SAVE;
         end else begin
            top_next.err_code = 1'b1;
         end
      end

      // Status versus selection display
      case (top_next.st)
         ST_SELECT, ST_SAVE: begin
            top_next.disp.sel_mode = 1'b1;
            top_next.disp.err      = 1'b0;
            top_next.disp.sym      = code_sym(top_next.cand);
         end
         ST_ERROR: begin
            top_next.disp.sel_mode = 1'b1;
            top_next.disp.err      = 1'b1;
            top_next.disp.sym      = SYM_ERR;
         end
         default: begin
            top_next.disp.sel_mode = 1'b0;
            top_next.disp.err      = 1'b0;
            top_next.disp.sym      = status_sym;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         top_reg <= '0;
      end else begin
         top_reg <= top_next;
      end
   end

   // APB answers in the first access cycle
   assign prdata  = top_reg.rdata;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !addr_hit;

   // Outputs toward store, display and drive
   assign disp                  = top_reg.disp;
   assign nv_req.req            = (top_reg.st == ST_SAVE);
   assign nv_req.code           = top_reg.cand;
   assign link_speed_code_param = top_reg.stored;
   assign ring_rate_mbd         = code_mbd(top_reg.stored);
   assign host_drive_bus_id     = eff_id;
   assign node_ignored          = (top_reg.node == '0);
   // One board only; nothing runs until the boot capture is done
   assign ring_en               = !top_reg.fb_sel && (top_reg.st != ST_BOOT);
   assign fieldbus_en           = top_reg.fb_sel && (top_reg.st != ST_BOOT);
   assign drive_rst_req         = top_reg.rst_pls;

endmodule
`default_nettype wire

// ---- hdl/rsb_pkg.sv ----
// Constants, types and helper functions for the ring speed button selector.
// Assumes a 100 MHz system clock; every long count is derived from it here.
package rsb_pkg;

   // Clock rate and the derived cycles per millisecond
   localparam int unsigned CLK_HZ     = 100_000_000;
   localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;

   // Operator timing, in milliseconds as specified
   localparam int unsigned LONG_MS  = 3000;
   localparam int unsigned SHORT_MS = 800;
   localparam int unsigned IDLE_MS  = 8000;
   localparam int unsigned DEB_MS   = 20;
   localparam int unsigned LONG_CYC  = LONG_MS * CYC_PER_MS;
   localparam int unsigned SHORT_CYC = SHORT_MS * CYC_PER_MS;
   localparam int unsigned IDLE_CYC  = IDLE_MS * CYC_PER_MS;
   localparam int unsigned DEB_CYC   = DEB_MS * CYC_PER_MS;

   // Widths
   localparam int unsigned CODE_W = 5;
   localparam int unsigned NODE_W = 4;
   localparam int unsigned EXT_W  = 4;
   localparam int unsigned ID_W   = 8;

   // Speed codes, legacy ones first
   localparam logic [4:0] SPD_LEG_4M = 5'h00;
   localparam logic [4:0] SPD_LEG_2M = 5'h01;
   localparam logic [4:0] SPD_2M     = 5'h02;
   localparam logic [4:0] SPD_4M     = 5'h04;
   localparam logic [4:0] SPD_8M     = 5'h08;
   localparam logic [4:0] SPD_16M    = 5'h10;

   // Display characters
   localparam logic [7:0] SYM_2   = 8'h32;
   localparam logic [7:0] SYM_4   = 8'h34;
   localparam logic [7:0] SYM_8   = 8'h38;
   localparam logic [7:0] SYM_16  = 8'h5D;
   localparam logic [7:0] SYM_ERR = 8'h45;

   // Ring addressing, fast channel capacity and boot capture count
   localparam logic [ID_W-1:0] ID_STEP    = 8'h0F;
   localparam logic [3:0]      FAST_IDN   = 4'h8;
   localparam logic [4:0]      FAST_WORDS = 5'h10;
   localparam logic [1:0]      INIT_DONE  = 2'h3;

   // Register map (byte addresses) and field positions
   localparam logic [11:0] OFS_CTRL  = 12'h000;
   localparam logic [11:0] OFS_STAT  = 12'h004;
   localparam logic [11:0] OFS_SPEED = 12'h008;
   localparam logic [11:0] OFS_NODE  = 12'h00C;
   localparam int unsigned CTRL_FB_BIT   = 8;
   localparam int unsigned STAT_ENV_BIT  = 8;
   localparam int unsigned STAT_ECOD_BIT = 9;
   localparam int unsigned STAT_CAND_LSB = 16;
   localparam int unsigned SPD_MBD_LSB   = 8;
   localparam int unsigned NODE_ID_LSB   = 8;
   localparam int unsigned NODE_IGN_BIT  = 16;
   localparam int unsigned NODE_IDN_LSB  = 20;
   localparam int unsigned NODE_WRD_LSB  = 24;

   // Selector states
   typedef enum logic [2:0] {ST_BOOT, ST_IDLE, ST_SELECT, ST_SAVE, ST_ERROR, ST_RESTART} rsb_st_e;

   // Nonvolatile store request and response, display drive
   typedef struct packed {
      logic              req;
      logic [CODE_W-1:0] code;
   } rsb_nv_req_s;
   typedef struct packed {
      logic ok;
      logic fail;
   } rsb_nv_rsp_s;
   typedef struct packed {
      logic       sel_mode;
      logic       err;
      logic [7:0] sym;
   } rsb_disp_s;

   // True for every code the hardware accepts
   function automatic logic code_valid(input logic [CODE_W-1:0] c);
      case (c)
         SPD_LEG_4M, SPD_LEG_2M, SPD_2M, SPD_4M, SPD_8M, SPD_16M: code_valid = 1'b1;
         default: code_valid = 1'b0;
      endcase
   endfunction

   // Legacy codes folded onto their modern equivalents
   function automatic logic [CODE_W-1:0] code_norm(input logic [CODE_W-1:0] c);
      case (c)
         SPD_LEG_4M: code_norm = SPD_4M;
         SPD_LEG_2M: code_norm = SPD_2M;
         default:    code_norm = c;
      endcase
   endfunction

   // Next candidate, wrapping from the top speed to the lowest
   function automatic logic [CODE_W-1:0] code_next(input logic [CODE_W-1:0] c);
      case (code_norm(c))
         SPD_2M:  code_next = SPD_4M;
         SPD_4M:  code_next = SPD_8M;
         SPD_8M:  code_next = SPD_16M;
         default: code_next = SPD_2M;
      endcase
   endfunction

   // Display character of a code
   function automatic logic [7:0] code_sym(input logic [CODE_W-1:0] c);
      case (code_norm(c))
         SPD_2M:  code_sym = SYM_2;
         SPD_4M:  code_sym = SYM_4;
         SPD_8M:  code_sym = SYM_8;
         SPD_16M: code_sym = SYM_16;
         default: code_sym = SYM_ERR;
      endcase
   endfunction

   // Rate in MBd; modern codes equal their rate, zero for a bad code
   function automatic logic [CODE_W-1:0] code_mbd(input logic [CODE_W-1:0] c);
      code_mbd = code_valid(c) ? code_norm(c) : 5'h00;
   endfunction

endpackage

// ---- hdl/rsb_press_timer.sv ----
// Button synchroniser, debouncer and press-length classifier.
// Assumes an active-low pushbutton pin from outside the clock domain.
`timescale 1ns/100ps
`default_nettype none
module rsb_press_timer
   import rsb_pkg::*;
#(
   parameter int unsigned DEB_N   = DEB_CYC,
   parameter int unsigned SHORT_N = SHORT_CYC,
   parameter int unsigned LONG_N  = LONG_CYC
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic sys_rst,
   // Button pin
   input  wire logic btn_n,
   // Classified events
   output logic      pressed,
   output logic      short_pls,
   output logic      long_pls
);

   typedef struct packed {
      logic        s1;
      logic        s2;
      logic        deb;
      logic [31:0] deb_cnt;
      logic [31:0] dur;
      logic        long_done;
      logic        short_pls;
      logic        long_pls;
   } rsb_pt_s;

   rsb_pt_s pt_reg;
   rsb_pt_s pt_next;

   // Debounce, then time the press from the debounced edges
   always_comb begin
      pt_next           = pt_reg;
      pt_next.s1        = ~btn_n;
      pt_next.s2        = pt_reg.s1;
      pt_next.short_pls = 1'b0;
      pt_next.long_pls  = 1'b0;
      // Both edges see the same debounce lag, so durations stay honest
      if (pt_reg.s2 != pt_reg.deb) begin
         pt_next.deb_cnt = pt_reg.deb_cnt + 32'h0000_0001;
         if (pt_reg.deb_cnt >= DEB_N - 1) begin
            pt_next.deb     = pt_reg.s2;
            pt_next.deb_cnt = 32'h0000_0000;
         end
      end else begin
         pt_next.deb_cnt = 32'h0000_0000;
      end
      if (pt_next.deb && !pt_reg.deb) begin
         pt_next.dur       = 32'h0000_0000;
         pt_next.long_done = 1'b0;
      end else if (pt_reg.deb) begin
         // Saturate so a very long hold cannot wrap into a short one
         if (pt_reg.dur < LONG_N) begin
            pt_next.dur = pt_reg.dur + 32'h0000_0001;
         end
         if (pt_reg.dur == LONG_N - 1 && !pt_reg.long_done) begin
            pt_next.long_pls  = 1'b1;
            pt_next.long_done = 1'b1;
         end
         // A release between the thresholds raises nothing
         if (!pt_next.deb && pt_reg.dur < SHORT_N) begin
            pt_next.short_pls = 1'b1;
         end
      end
   end

   // State register
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pt_reg <= '0;
      end else begin
         pt_reg <= pt_next;
      end
   end

   assign pressed   = pt_reg.deb;
   assign short_pls = pt_reg.short_pls;
   assign long_pls  = pt_reg.long_pls;

endmodule
`default_nettype wire

// ---- dv/rsb_nv_model.sv ----
// Behavioural nonvolatile parameter store at the far side of the selector.
// Assumes requests are held until answered; contents survive sys_rst.
`timescale 1ns/100ps
`default_nettype none
module rsb_nv_model
   import rsb_pkg::*;
#(
   parameter logic [CODE_W-1:0] INIT = SPD_4M
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              sys_rst,
   // Store port
   input  wire rsb_nv_req_s       nv_req,
   output var  rsb_nv_rsp_s       nv_rsp,
   output logic [CODE_W-1:0]      nv_boot_code,
   // Bench controls
   input  wire logic              fail_mode,
   input  wire logic [3:0]        lat
);
   logic [3:0]        cnt;
   logic [CODE_W-1:0] mem = INIT;
   assign nv_boot_code = mem;
   // One answer pulse lat plus one cycles after the request; memory is never cleared by reset
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt <= '0;
         nv_rsp <= '0;
      end else begin
         nv_rsp <= '0;
         if (!nv_req.req || nv_rsp.ok || nv_rsp.fail) cnt <= '0;
         else if (cnt == lat) begin
            nv_rsp.ok <= !fail_mode;
            nv_rsp.fail <= fail_mode;
            if (!fail_mode) mem <= nv_req.code;
         end else cnt <= cnt + 4'h1;
      end
   end
endmodule
`default_nettype wire

// ---- dv/rsb_speed_selector_chk.sv ----
// Port checks for the speed selector.
// Assumes one clock domain and asynchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module rsb_chk
   import rsb_pkg::*;
#(
   parameter int unsigned DEB_N  = DEB_CYC,
   parameter int unsigned IDLE_N = IDLE_CYC
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              sys_rst,
   // Operator side
   input  wire logic              boot_btn_n,
   input  wire rsb_disp_s         disp,
   // Store and drive side
   input  wire rsb_nv_req_s       nv_req,
   input  wire rsb_nv_rsp_s       nv_rsp,
   input  wire logic [CODE_W-1:0] link_speed_code_param,
   input  wire logic [CODE_W-1:0] ring_rate_mbd,
   input  wire logic              ring_en,
   input  wire logic              fieldbus_en,
   input  wire logic              drive_rst_req
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic [31:0] quiet_reg;
   // Released cycles in selection; a counter, since the span is too long to unroll
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) quiet_reg <= '0;
      else if (disp.sel_mode && !disp.err && boot_btn_n) quiet_reg <= quiet_reg + 32'h0000_0001;
      else quiet_reg <= '0;
   end
   sequence s_save_ok;
      nv_req.req && nv_rsp.ok && !nv_rsp.fail;
   endsequence
   sequence s_restart;
      drive_rst_req ##1 !drive_rst_req;
   endsequence
   a_ok_restart: assert property (s_save_ok |=> s_restart) else $error("no single restart pulse");
   a_ok_stores: assert property (s_save_ok |=> link_speed_code_param == $past(nv_req.code))
      else $error("saved code not stored");
   a_fail_keeps: assert property (nv_req.req && nv_rsp.fail |=> $stable(link_speed_code_param))
      else $error("failed save changed code");
   a_fail_shows: assert property (nv_req.req && nv_rsp.fail |-> ##[1:3] disp.err)
      else $error("no error shown");
   a_err_symbol: assert property (disp.err |-> disp.sel_mode && disp.sym == SYM_ERR)
      else $error("bad error display");
   a_one_board: assert property (!(ring_en && fieldbus_en)) else $error("both boards on");
   a_rate_map: assert property (link_speed_code_param inside {5'h00, 5'h01, 5'h02, 5'h04, 5'h08, 5'h10}
      |-> ring_rate_mbd == (link_speed_code_param == 5'h00 ? 5'h04 :
      link_speed_code_param == 5'h01 ? 5'h02 : link_speed_code_param)) else $error("bad rate");
   a_req_valid: assert property (nv_req.req |-> nv_req.code inside {5'h00, 5'h01, 5'h02, 5'h04, 5'h08, 5'h10})
      else $error("invalid code saved");
   a_idle_bound: assert property (quiet_reg <= IDLE_N + DEB_N + 8) else $error("selection timeout late");
endmodule
bind rsb_speed_selector rsb_chk #(.DEB_N(DEB_N), .IDLE_N(IDLE_N)) u_chk (
   .clk(clk), .sys_rst(sys_rst), .boot_btn_n(boot_btn_n), .disp(disp), .nv_req(nv_req),
   .nv_rsp(nv_rsp), .link_speed_code_param(link_speed_code_param), .ring_rate_mbd(ring_rate_mbd),
   .ring_en(ring_en), .fieldbus_en(fieldbus_en), .drive_rst_req(drive_rst_req));
`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking bench for the speed selector with shortened timing.
// Assumes the package, selector, checker and store model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_top
   import rsb_pkg::*;
   ;
   localparam int unsigned DN = 4;
   localparam int unsigned LN = 100;
   localparam int unsigned IN = 300;
   typedef struct {int hold; logic [4:0] cand; logic [7:0] sym;} rsb_row_s;
   logic              clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic              boot_btn_n = 1'b1, fail_mode = 1'b0, pready, pslverr, err;
   logic              ring_en, fieldbus_en, drive_rst_req, node_ignored;
   logic [11:0]       paddr = '0;
   logic [31:0]       pwdata = '0, prdata, rd;
   logic [7:0]        status_sym = 8'h41, host_drive_bus_id;
   logic [3:0]        node_sw = 4'h9, lat = 4'h0;
   logic [CODE_W-1:0] nv_boot_code, link_speed_code_param, ring_rate_mbd;
   rsb_disp_s         disp;
   rsb_nv_req_s       nv_req;
   rsb_nv_rsp_s       nv_rsp;
   int                n_fail = 0, checked = 0, rst_seen = 0;
   // Short presses step, a mid-length press does nothing
   rsb_row_s rows [5] = '{'{20, SPD_4M, SYM_4}, '{20, SPD_8M, SYM_8}, '{20, SPD_16M, SYM_16},
                          '{20, SPD_2M, SYM_2}, '{70, SPD_2M, SYM_2}};
   always #5 clk = ~clk;
   always @(posedge clk) if (drive_rst_req === 1'b1) rst_seen++;
   rsb_speed_selector #(.DEB_N(DN), .SHORT_N(40), .LONG_N(LN), .IDLE_N(IN)) uut (
      .clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .boot_btn_n(boot_btn_n),
      .status_sym(status_sym), .disp(disp), .node_sw(node_sw), .nv_boot_code(nv_boot_code),
      .nv_req(nv_req), .nv_rsp(nv_rsp), .link_speed_code_param(link_speed_code_param),
      .ring_rate_mbd(ring_rate_mbd), .host_drive_bus_id(host_drive_bus_id), .node_ignored(node_ignored),
      .ring_en(ring_en), .fieldbus_en(fieldbus_en), .drive_rst_req(drive_rst_req));
   rsb_nv_model #(.INIT(SPD_LEG_2M)) u_nv (.clk(clk), .sys_rst(sys_rst), .nv_req(nv_req),
      .nv_rsp(nv_rsp), .nv_boot_code(nv_boot_code), .fail_mode(fail_mode), .lat(lat));
   task automatic stop_test();
      if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One APB transfer; the hang guard is the watchdog, not a count
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic push(input int hold);
      boot_btn_n <= 1'b0;
      repeat (hold) @(posedge clk);
      boot_btn_n <= 1'b1;
      repeat (DN + 20) @(posedge clk);
   endtask
   task automatic reboot();
      sys_rst <= 1'b1;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (6) @(posedge clk);
   endtask
   initial begin
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (6) @(posedge clk);
      chk(ring_rate_mbd, 5'h02);
      chk(disp, {2'b00, 8'h41});
      chk(host_drive_bus_id, 8'h09);
      apb(1'b0, OFS_NODE, '0);
      chk(rd[28:20], {5'h10, 4'h8});
      push(LN + 20);
      chk(disp, {2'b10, SYM_2});
      foreach (rows[i]) begin
         push(rows[i].hold);
         apb(1'b0, OFS_STAT, '0);
         chk({rd[20:16], rd[2:0], disp.sym}, {rows[i].cand, 3'h2, rows[i].sym});
      end
      // Abandon by timeout; nothing may change
      status_sym <= 8'h42;
      repeat (IN + 20) @(posedge clk);
      chk(disp, {2'b00, 8'h42});
      chk(link_speed_code_param, SPD_LEG_2M);
      // Slow failing save, error held while pressed
      push(LN + 20);
      push(20);
      fail_mode <= 1'b1;
      lat <= 4'h9;
      boot_btn_n <= 1'b0;
      repeat (LN + 40) @(posedge clk);
      chk(disp, {2'b11, SYM_ERR});
      push(1);
      apb(1'b0, OFS_STAT, '0);
      chk({rd[8], rd[2:0], link_speed_code_param}, {1'b1, 3'h2, SPD_LEG_2M});
      fail_mode <= 1'b0;
      push(LN + 20);
      chk({link_speed_code_param, ring_rate_mbd}, {SPD_4M, 5'h04});
      chk(rst_seen, 1);
      // Register side: extension, board choice, bad code, unmapped place
      apb(1'b1, OFS_CTRL, 32'h0000_0101);
      chk({fieldbus_en, ring_en, host_drive_bus_id}, {2'b10, 8'h18});
      apb(1'b1, OFS_SPEED, 32'h0000_0003);
      apb(1'b0, OFS_STAT, '0);
      chk({rd[9], link_speed_code_param}, {1'b1, SPD_4M});
      apb(1'b0, 12'h010, '0);
      chk(rd, 32'h0000_0000);
      chk({30'h0000_0000, pready, err}, 32'h0000_0003);
      apb(1'b1, OFS_SPEED, 32'h0000_0008);
      // Save takes lat plus two cycles; look well after the store edge
      repeat (20) @(posedge clk);
      chk(link_speed_code_param, SPD_8M);
      // Reset in mid-selection with a moved switch
      node_sw <= 4'h0;
      push(LN + 20);
      push(20);
      chk({node_ignored, host_drive_bus_id}, {1'b0, 8'h18});
      reboot();
      chk({node_ignored, ring_en, link_speed_code_param}, {2'b11, SPD_8M});
      // Legacy code committed by software keeps its value and maps to 4 MBd
      apb(1'b1, OFS_SPEED, 32'h0000_0000);
      repeat (20) @(posedge clk);
      chk({link_speed_code_param, ring_rate_mbd}, {SPD_LEG_4M, 5'h04});
      stop_test();
   end
   // Watchdog well beyond the expected run of about 1530 cycles
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      stop_test();
   end
endmodule
`default_nettype wire
